// [bench/tcvb_channel_sva.sv]
`timescale 1ns/1ns

// ----------------------------------------
// Channel checker
// ----------------------------------------
module tcvb_channel_sva #(
   parameter int unsigned ADDR_W = tcvb_pkg::ADDR_W
) (
   input wire logic pclk,
   input wire logic presetn,
   input wire logic psel,
   input wire logic penable,
   input wire logic pwrite,
   input wire logic [ADDR_W-1:0] paddr,
   input wire logic [31:0] pwdata,
   input wire logic [31:0] prdata,
   input wire logic pready,
   input wire logic pslverr,
   input wire logic debug_halt_mode,
   input wire tcvb_pkg::tcvb_cnt_t cnt,
   input wire logic ch_pin_in,
   input wire logic ch_pin_out,
   input wire logic ch_pin_oe,
   input wire logic ch_irq,
   input wire logic center_pwm_select,
   input wire logic [1:0] counter_clock_select
);
   logic [1:0] ms_sh;
   logic [1:0] els_sh;
   logic ie_sh;
   logic acc;
   assign acc = psel && penable;
   // Shadow of control fields
   always_ff @(posedge pclk or negedge presetn)
   begin
      if (!presetn)
      begin
         ms_sh <= 2'h0;
         els_sh <= 2'h0;
         ie_sh <= 1'b0;
      end
      else if (acc && pwrite && paddr == tcvb_pkg::OFF_CHSC)
      begin
         ms_sh <= pwdata[5:4];
         els_sh <= pwdata[3:2];
         ie_sh <= pwdata[6];
      end
   end
   default clocking @(posedge pclk); endclocking
   default disable iff (!presetn);
   AST_PIN_OFF: assert property (els_sh == 2'h0 |-> !ch_pin_oe)
      else $error("Pin driven while released");
   AST_CAPT_OE: assert property (!center_pwm_select && ms_sh == 2'h0 |-> !ch_pin_oe)
      else $error("Pin driven in capture mode");
   AST_CMP_OE: assert property (!center_pwm_select && ms_sh == 2'h1 && els_sh != 2'h0 |-> ch_pin_oe)
      else $error("Compare pin not driven");
   AST_PWM_OE: assert property ((center_pwm_select || ms_sh[1]) && els_sh != 2'h0 |-> ch_pin_oe)
      else $error("PWM pin not driven");
   AST_IRQ_OFF: assert property (!ie_sh |-> !ch_irq)
      else $error("Request while disabled");
   AST_CAPT_IRQ: assert property (!center_pwm_select && ms_sh == 2'h0 && ie_sh &&
      ((els_sh == 2'h1 && $rose(ch_pin_in)) || (els_sh == 2'h2 && $fell(ch_pin_in))) |-> ##[1:6] ch_irq)
      else $error("No request after capture edge");
   AST_SETUP: assert property (acc && pwrite && paddr == tcvb_pkg::OFF_SETUP |=>
      center_pwm_select == $past(pwdata[5]) && counter_clock_select == $past(pwdata[4:3]))
      else $error("Setup outputs wrong");
   AST_RD_BYTE: assert property (acc && !pwrite |-> prdata[31:8] == 24'h000000)
      else $error("Read upper bits set");
endmodule

// [bench/tcvb_channel_tb.sv]
`timescale 1ns/1ns

module tcvb_channel_tb;
   localparam logic [3:0] H = tcvb_pkg::OFF_VALH;
   localparam logic [3:0] L = tcvb_pkg::OFF_VALL;
   localparam logic [3:0] C = tcvb_pkg::OFF_CHSC;
   logic pclk = 1'b0;
   logic presetn = 1'b0;
   logic psel = 1'b0;
   logic penable = 1'b0;
   logic pwrite = 1'b0;
   logic [3:0] paddr = 4'h0;
   logic [31:0] pwdata = 32'h0;
   logic [31:0] prdata;
   logic pready;
   logic pslverr;
   logic dbg = 1'b0;
   tcvb_pkg::tcvb_cnt_t cnt = 34'h1;
   logic pin_in;
   logic pin_out;
   logic pin_oe;
   logic irq;
   logic ext = 1'b0;
   logic err;
   logic [7:0] dum;
   int n_errors = 0;
   int tests_run = 0;
   int cyc = 0;

   tcvb_channel i_dut (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable), .pwrite(pwrite),
      .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
      .debug_halt_mode(dbg), .cnt(cnt), .ch_pin_in(pin_in), .ch_pin_out(pin_out), .ch_pin_oe(pin_oe),
      .ch_irq(irq), .center_pwm_select(), .counter_clock_select());
   tcvb_pin_model i_pin (.drv_level(ext), .ch_pin_out(pin_out), .ch_pin_oe(pin_oe), .ch_pin_in(pin_in));

   initial
   begin
      forever #50 pclk = ~pclk;
   end

   // ----------------------------------------
   // Shared tasks
   // ----------------------------------------
   task close_out;
      begin
         $display("comparisons %0d mismatches %0d", tests_run, n_errors);
         if (n_errors == 0 && tests_run > 0)
            $display("Testbench passed");
         else
            $display("Testbench failed");
         $finish;
      end
   endtask

   always @(posedge pclk)
   begin
      cyc++;
      if (cyc == 20000)
      begin
         n_errors++;
         close_out;
      end
   end

   task chk(input logic [15:0] s, input logic [15:0] e);
      begin
         tests_run++;
         if (s !== e)
         begin
            n_errors++;
            $display("ERROR at %0t: seen %h expected %h", $time, s, e);
         end
      end
   endtask

   task apb(input logic w, input logic [3:0] a, input logic [7:0] d, output logic [7:0] r);
      begin
         psel <= 1'b1;
         pwrite <= w;
         paddr <= a;
         pwdata <= {24'h0, d};
         @(posedge pclk);
         penable <= 1'b1;
         @(posedge pclk);
         while (pready !== 1'b1)
            @(posedge pclk);
         r = prdata[7:0];
         err = pslverr;
         psel <= 1'b0;
         penable <= 1'b0;
         @(posedge pclk);
      end
   endtask

   task wr(input logic [3:0] a, input logic [7:0] d);
      apb(1'b1, a, d, dum);
   endtask

   task rc(input logic [3:0] a, input logic [7:0] e);
      begin
         apb(1'b0, a, 8'h00, dum);
         chk({8'h00, dum}, {8'h00, e});
      end
   endtask

   task cfg(input logic [1:0] ms, input logic [1:0] els, input logic ie);
      wr(C, {1'b0, ie, ms, els, 2'b00});
   endtask

   task stp(input logic cp, input logic [1:0] ck);
      wr(tcvb_pkg::OFF_SETUP, {2'b00, cp, ck, 3'b000});
   endtask

   task tk(input logic [15:0] v);
      begin
         cnt.value <= v;
         cnt.tick <= 1'b1;
         @(posedge pclk);
         cnt.tick <= 1'b0;
         repeat (2) @(posedge pclk);
      end
   endtask

   task pn(input logic [15:0] v, input logic l);
      begin
         cnt.value <= v;
         ext <= l;
         repeat (6) @(posedge pclk);
      end
   endtask

   task pc(input logic [1:0] ms, input logic [1:0] els, input logic [15:0] v, input logic e);
      begin
         cfg(ms, els, 1'b0);
         tk(v);
         chk({15'h0, pin_out}, {15'h0, e});
      end
   endtask

   // ----------------------------------------
   // Scenarios
   // ----------------------------------------
   task t_write;
      begin
         rc(H, 8'h00);
         rc(L, 8'h00);
         stp(1'b0, 2'h0);
         cfg(2'h1, 2'h0, 1'b0);
         wr(H, 8'h9A);
         rc(H, 8'h00);
         wr(L, 8'hBC);
         rc(H, 8'h9A);
         wr(L, 8'h02);
         cfg(2'h1, 2'h0, 1'b0);
         wr(H, 8'h03);
         rc(H, 8'h9A);
         wr(L, 8'h04);
         rc(L, 8'h04);
         wr(H, 8'h11);
         dbg <= 1'b1;
         wr(L, 8'h22);
         rc(L, 8'h22);
         rc(H, 8'h03);
         dbg <= 1'b0;
         wr(L, 8'h33);
         rc(H, 8'h11);
         rc(L, 8'h33);
         stp(1'b0, 2'h1);
         wr(H, 8'h56);
         wr(L, 8'h78);
         rc(L, 8'h33);
         tk(16'h0000);
         rc(H, 8'h56);
         cfg(2'h2, 2'h2, 1'b0);
         wr(H, 8'h12);
         wr(L, 8'h34);
         tk(16'hFFFE);
         rc(H, 8'h56);
         tk(16'hFFFF);
         rc(H, 8'h12);
         rc(L, 8'h34);
         cnt.modulo <= 16'h0100;
         wr(H, 8'h21);
         wr(L, 8'h43);
         tk(16'h00FF);
         rc(H, 8'h12);
         tk(16'h0100);
         rc(L, 8'h43);
         cnt.modulo <= 16'h0000;
         apb(1'b0, 4'h2, 8'h00, dum);
         chk({15'h0, err}, 16'h0001);
         $display("write buffering done");
      end
   endtask

   task t_pins;
      begin
         stp(1'b0, 2'h0);
         cfg(2'h1, 2'h0, 1'b0);
         wr(H, 8'h00);
         wr(L, 8'h10);
         pc(2'h1, 2'h3, 16'h0010, 1'b1);
         pc(2'h1, 2'h2, 16'h0010, 1'b0);
         pc(2'h1, 2'h1, 16'h0010, 1'b1);
         pc(2'h1, 2'h1, 16'h0010, 1'b0);
         pc(2'h1, 2'h3, 16'h0110, 1'b0);
         pc(2'h2, 2'h2, 16'h0000, 1'b1);
         pc(2'h2, 2'h2, 16'h0010, 1'b0);
         pc(2'h3, 2'h1, 16'h0000, 1'b0);
         pc(2'h3, 2'h3, 16'h0010, 1'b1);
         stp(1'b1, 2'h0);
         pc(2'h2, 2'h2, 16'h0010, 1'b0);
         pc(2'h0, 2'h1, 16'h0010, 1'b1);
         cfg(2'h2, 2'h0, 1'b0);
         chk({15'h0, pin_oe}, 16'h0000);
         $display("pin modes done");
      end
   endtask

   task t_cap;
      begin
         stp(1'b0, 2'h0);
         cfg(2'h0, 2'h1, 1'b1);
         apb(1'b0, C, 8'h00, dum);
         cfg(2'h0, 2'h1, 1'b1);
         chk({15'h0, irq}, 16'h0000);
         pn(16'h0A0B, 1'b1);
         chk({15'h0, irq}, 16'h0001);
         rc(H, 8'h0A);
         pn(16'h0000, 1'b0);
         pn(16'h0C0D, 1'b1);
         rc(L, 8'h0B);
         wr(H, 8'hFF);
         rc(H, 8'h0C);
         cfg(2'h0, 2'h1, 1'b1);
         pn(16'h0000, 1'b0);
         pn(16'h0E0F, 1'b1);
         rc(L, 8'h0F);
         dbg <= 1'b1;
         pn(16'h0000, 1'b0);
         pn(16'h1011, 1'b1);
         rc(H, 8'h10);
         dbg <= 1'b0;
         rc(H, 8'h0E);
         cfg(2'h0, 2'h2, 1'b0);
         pn(16'h7777, 1'b0);
         pn(16'h6666, 1'b1);
         rc(H, 8'h77);
         cfg(2'h0, 2'h3, 1'b0);
         pn(16'h5555, 1'b0);
         rc(H, 8'h55);
         rc(L, 8'h55);
         pn(16'h4444, 1'b1);
         rc(L, 8'h44);
         $display("capture done");
      end
   endtask

   initial
   begin
      repeat (20) @(posedge pclk);
      presetn <= 1'b1;
      @(posedge pclk);
      t_write;
      t_pins;
      t_cap;
      close_out;
   end
endmodule

bind tcvb_channel tcvb_channel_sva #(.ADDR_W(ADDR_W)) i_sva (.pclk(pclk), .presetn(presetn), .psel(psel),
   .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
   .pslverr(pslverr), .debug_halt_mode(debug_halt_mode), .cnt(cnt), .ch_pin_in(ch_pin_in),
   .ch_pin_out(ch_pin_out), .ch_pin_oe(ch_pin_oe), .ch_irq(ch_irq), .center_pwm_select(center_pwm_select),
   .counter_clock_select(counter_clock_select));

// [bench/tcvb_pin_model.sv]
`timescale 1ns/1ns

// ----------------------------------------
// Pin seen from outside
// ----------------------------------------
module tcvb_pin_model (
   input wire logic drv_level,
   input wire logic ch_pin_out,
   input wire logic ch_pin_oe,
   output logic ch_pin_in
);
   // Channel wins while driving, else outside level
   assign ch_pin_in = ch_pin_oe ? ch_pin_out : drv_level;
endmodule

// [hw/tcvb_channel.sv]
`timescale 1ns/1ns

// Operation
// (R01) Edge/level 00 releases the channel pin
// (R02) Mode 00: capture rising, falling or both
// (R03) Mode 01: compare soft, toggle, clear, set
// (R04) Mode 1X: edge PWM high or low true
// (R05) Center select: center PWM on up match; the code also switches the pin on down match
// (R06) Reset clears both value bytes
// (R07) Capture read latches both bytes until other
// (R08) Control write releases read latch
// (R09) Capture mode ignores value writes
// (R10) Debug freezes read latch state
// (R11) Debug reads return live value
// (R12) Compare/PWM writes buffered, transfer after both
// (R13) Counter stopped: transfer on second write
// (R14) Compare: transfer at next counter change
// (R15) PWM: transfer at step to modulo
// (R16) Control write resets write sequence
// (R17) Debug freezes write latch state
// (R18) Debug writes go straight to value
// (R19) Debug writes keep partial sequence intact
// (R20) Capture edge copies counter into value
// (R21) Flag on capture or match, interrupt
// (R22) Center select drives up/down counting
// (R23) Match compares full 16-bit counter value
// (R24) Value is high and low byte
module tcvb_channel #(
   parameter int unsigned ADDR_W = tcvb_pkg::ADDR_W
) (
   input wire logic pclk,
   input wire logic presetn,
   input wire logic psel,
   input wire logic penable,
   input wire logic pwrite,
   input wire logic [ADDR_W-1:0] paddr,
   input wire logic [31:0] pwdata,
   output logic [31:0] prdata,
   output logic pready,
   output logic pslverr,
   input wire logic debug_halt_mode,
   input wire tcvb_pkg::tcvb_cnt_t cnt,
   input wire logic ch_pin_in,
   output logic ch_pin_out,
   output logic ch_pin_oe,
   output logic ch_irq,
   output logic center_pwm_select,
   output logic [1:0] counter_clock_select
);

   // ----------------------------------------
   // Types and state
   // ----------------------------------------
   typedef enum logic [1:0] {TCVB_WR_IDLE, TCVB_WR_HI, TCVB_WR_LO, TCVB_WR_FULL} tcvb_wr_t;
   typedef enum logic [1:0] {TCVB_RD_OPEN, TCVB_RD_HI, TCVB_RD_LO} tcvb_rd_t;

   tcvb_pkg::tcvb_chsc_t chsc_reg;
   logic flag_armed_reg;
   logic [15:0] val_reg;
   logic [15:0] wr_buf_reg;
   logic [15:0] rd_buf_reg;
   tcvb_wr_t wr_state_reg;
   tcvb_rd_t rd_state_reg;
   logic [2:0] pin_sync_reg;
   logic pin_level_reg;
   logic [31:0] prdata_reg;

   // ----------------------------------------
   // Mode decode
   // ----------------------------------------
   function automatic tcvb_pkg::tcvb_mode_t decode_mode(input logic center_aligned_pwm, input logic [1:0] ms);
      tcvb_pkg::tcvb_mode_t m;
      m = tcvb_pkg::TCVB_CAPTURE;
      if (center_aligned_pwm)
      begin
         m = tcvb_pkg::TCVB_CENTER_ALIGNED_PWM; // (R05)
      end
      else if (ms[1])
      begin
         m = tcvb_pkg::TCVB_EDGE_ALIGNED_PWM; // (R04)
      end
      else if (ms == tcvb_pkg::MS_COMPARE)
      begin
         m = tcvb_pkg::TCVB_COMPARE; // (R03)
      end
      else
      begin
         m = tcvb_pkg::TCVB_CAPTURE; // (R02)
      end
      return m;
   endfunction

   // Address match against one word offset
   function automatic logic hit(input logic [ADDR_W-1:0] a, input logic [3:0] off);
      return a == ADDR_W'(off);
   endfunction

   tcvb_pkg::tcvb_mode_t mode;
   logic is_capture;
   logic is_pwm;
   logic clks_off;
   logic high_true;
   logic [15:0] term;

   assign mode = decode_mode(center_pwm_select, chsc_reg.ms);
   assign is_capture = (mode == tcvb_pkg::TCVB_CAPTURE);
   assign is_pwm = (mode == tcvb_pkg::TCVB_EDGE_ALIGNED_PWM) || (mode == tcvb_pkg::TCVB_CENTER_ALIGNED_PWM);
   assign clks_off = (counter_clock_select == tcvb_pkg::CLKS_RST);
   assign high_true = (chsc_reg.els == tcvb_pkg::ELS_HIGH_TRUE);
   assign term = (cnt.modulo == tcvb_pkg::CNT_ZERO) ? tcvb_pkg::FREE_TERM : cnt.modulo;

   // ----------------------------------------
   // APB decode
   // ----------------------------------------
   logic acc;
   logic mapped;
   logic wr_chsc;
   logic wr_valh;
   logic wr_vall;
   logic wr_setup;
   logic rd_chsc;
   logic rd_valh;
   logic rd_vall;

   assign pready = psel & penable;
   assign acc = psel & penable;

   always_comb
   begin
      mapped = 1'b1;
      if (hit(paddr, tcvb_pkg::OFF_CHSC))
      begin
         mapped = 1'b1;
      end
      else if (hit(paddr, tcvb_pkg::OFF_VALH))
      begin
         mapped = 1'b1;
      end
      else if (hit(paddr, tcvb_pkg::OFF_VALL))
      begin
         mapped = 1'b1;
      end
      else if (hit(paddr, tcvb_pkg::OFF_SETUP))
      begin
         mapped = 1'b1;
      end
      else
      begin
         mapped = 1'b0;
      end
   end

   assign pslverr = acc & ~mapped;
   assign wr_chsc = acc & pwrite & hit(paddr, tcvb_pkg::OFF_CHSC);
   assign wr_valh = acc & pwrite & hit(paddr, tcvb_pkg::OFF_VALH);
   assign wr_vall = acc & pwrite & hit(paddr, tcvb_pkg::OFF_VALL);
   assign wr_setup = acc & pwrite & hit(paddr, tcvb_pkg::OFF_SETUP);
   assign rd_chsc = acc & ~pwrite & hit(paddr, tcvb_pkg::OFF_CHSC);
   assign rd_valh = acc & ~pwrite & hit(paddr, tcvb_pkg::OFF_VALH);
   assign rd_vall = acc & ~pwrite & hit(paddr, tcvb_pkg::OFF_VALL);

   // ----------------------------------------
   // Pin synchroniser and edge detect
   // ----------------------------------------
   logic pin_stable;
   logic rise_evt;
   logic fall_evt;
   logic cap_evt;
   logic match_evt;

   always_ff @(posedge pclk or negedge presetn)
   begin
      if (!presetn)
      begin
         pin_sync_reg <= 3'h0;
         pin_level_reg <= 1'b0;
      end
      else
      begin
         pin_sync_reg <= {pin_sync_reg[1:0], ch_pin_in};
         if (pin_stable)
         begin
            pin_level_reg <= pin_sync_reg[2];
         end
      end
   end

   assign pin_stable = (pin_sync_reg[1] == pin_sync_reg[2]);
   assign rise_evt = pin_stable & pin_sync_reg[2] & ~pin_level_reg;
   assign fall_evt = pin_stable & ~pin_sync_reg[2] & pin_level_reg;

   always_comb
   begin
      cap_evt = 1'b0;
      if (is_capture)
      begin
         case (chsc_reg.els)
            tcvb_pkg::ELS_RISE: cap_evt = rise_evt; // (R02)
            tcvb_pkg::ELS_FALL: cap_evt = fall_evt; // (R02)
            tcvb_pkg::ELS_BOTH: cap_evt = rise_evt | fall_evt; // (R02)
            default: cap_evt = 1'b0;
         endcase
      end
   end

   assign match_evt = ~is_capture & cnt.tick & (cnt.value == val_reg); // (R23)

   // ----------------------------------------
   // Timer setup register
   // ----------------------------------------
   always_ff @(posedge pclk or negedge presetn)
   begin
      if (!presetn)
      begin
         center_pwm_select <= 1'b0;
         counter_clock_select <= tcvb_pkg::CLKS_RST;
      end
      else if (wr_setup)
      begin
         center_pwm_select <= pwdata[tcvb_pkg::SETUP_CENTER_ALIGNED_PWM_BIT]; // (R22)
         counter_clock_select <= pwdata[tcvb_pkg::SETUP_CLKS_LSB +: 2];
      end
   end

   // ----------------------------------------
   // Channel status/control and flag
   // ----------------------------------------
   always_ff @(posedge pclk or negedge presetn)
   begin
      if (!presetn)
      begin
         chsc_reg <= '0;
         flag_armed_reg <= 1'b0;
      end
      else
      begin
         if (wr_chsc)
         begin
            chsc_reg.irq_en <= pwdata[tcvb_pkg::CHSC_IE_BIT];
            chsc_reg.ms <= pwdata[tcvb_pkg::CHSC_MS_LSB +: 2];
            chsc_reg.els <= pwdata[tcvb_pkg::CHSC_ELS_LSB +: 2];
            if (flag_armed_reg && !pwdata[tcvb_pkg::CHSC_FLAG_BIT])
            begin
               chsc_reg.flag <= 1'b0;
            end
            flag_armed_reg <= 1'b0;
         end
         else if (rd_chsc && chsc_reg.flag)
         begin
            flag_armed_reg <= 1'b1;
         end
         if (cap_evt || match_evt)
         begin
            chsc_reg.flag <= 1'b1; // (R21)
         end
      end
   end

   assign ch_irq = chsc_reg.flag & chsc_reg.irq_en; // (R21)

   // ----------------------------------------
   // Write coherency sequence
   // ----------------------------------------
   logic val_wr;
   logic second_wr;
   logic xfer_evt;

   assign val_wr = (wr_valh | wr_vall) & ~is_capture; // (R09)
   assign second_wr = (wr_valh && wr_state_reg == TCVB_WR_LO) || (wr_vall && wr_state_reg == TCVB_WR_HI);

   always_comb
   begin
      xfer_evt = 1'b0;
      if (wr_state_reg == TCVB_WR_FULL && !clks_off && cnt.tick && !debug_halt_mode)
      begin
         if (mode == tcvb_pkg::TCVB_COMPARE)
         begin
            xfer_evt = 1'b1; // (R14)
         end
         else if (is_pwm && cnt.up && cnt.value == term)
         begin
            xfer_evt = 1'b1; // (R15)
         end
      end
   end

   always_ff @(posedge pclk or negedge presetn)
   begin
      if (!presetn)
      begin
         wr_state_reg <= TCVB_WR_IDLE;
         wr_buf_reg <= tcvb_pkg::VAL_RST;
      end
      else if (wr_chsc)
      begin
         wr_state_reg <= TCVB_WR_IDLE; // (R16)
      end
      else if (debug_halt_mode)
      begin
         wr_state_reg <= wr_state_reg; // (R17) (R19)
      end
      else if (val_wr)
      begin
         if (wr_valh)
         begin
            wr_buf_reg[15:8] <= pwdata[7:0]; // (R12)
         end
         else
         begin
            wr_buf_reg[7:0] <= pwdata[7:0]; // (R12)
         end
         if (second_wr)
         begin
            wr_state_reg <= clks_off ? TCVB_WR_IDLE : TCVB_WR_FULL; // (R13)
         end
         else
         begin
            wr_state_reg <= wr_valh ? TCVB_WR_HI : TCVB_WR_LO;
         end
      end
      else if (xfer_evt)
      begin
         wr_state_reg <= TCVB_WR_IDLE;
      end
   end

   // ----------------------------------------
   // Channel value register
   // ----------------------------------------
   always_ff @(posedge pclk or negedge presetn)
   begin
      if (!presetn)
      begin
         val_reg <= tcvb_pkg::VAL_RST; // (R06)
      end
      else if (cap_evt)
      begin
         val_reg <= cnt.value; // (R20)
      end
      else if (val_wr && debug_halt_mode)
      begin
         if (wr_valh)
         begin
            val_reg[15:8] <= pwdata[7:0]; // (R18) (R24)
         end
         else
         begin
            val_reg[7:0] <= pwdata[7:0]; // (R18) (R24)
         end
      end
      else if (val_wr && second_wr && !wr_chsc && clks_off)
      begin
         val_reg <= wr_valh ? {pwdata[7:0], wr_buf_reg[7:0]} : {wr_buf_reg[15:8], pwdata[7:0]}; // (R13)
      end
      else if (xfer_evt && !wr_chsc)
      begin
         val_reg <= wr_buf_reg; // (R12) (R19)
      end
   end

   // ----------------------------------------
   // Read coherency latch
   // ----------------------------------------
   always_ff @(posedge pclk or negedge presetn)
   begin
      if (!presetn)
      begin
         rd_state_reg <= TCVB_RD_OPEN;
         rd_buf_reg <= tcvb_pkg::VAL_RST;
      end
      else if (wr_chsc)
      begin
         rd_state_reg <= TCVB_RD_OPEN; // (R08)
      end
      else if (!debug_halt_mode && is_capture && (rd_valh || rd_vall)) // (R10)
      begin
         case (rd_state_reg)
            TCVB_RD_OPEN:
            begin
               rd_buf_reg <= val_reg; // (R07)
               rd_state_reg <= rd_valh ? TCVB_RD_HI : TCVB_RD_LO;
            end
            TCVB_RD_HI:
            begin
               if (rd_vall)
               begin
                  rd_state_reg <= TCVB_RD_OPEN; // (R07)
               end
            end
            TCVB_RD_LO:
            begin
               if (rd_valh)
               begin
                  rd_state_reg <= TCVB_RD_OPEN; // (R07)
               end
            end
            default: rd_state_reg <= TCVB_RD_OPEN;
         endcase
      end
   end

   // ----------------------------------------
   // Read data, registered in the setup cycle
   // ----------------------------------------
   logic use_buf;
   logic [15:0] rd_word;

   assign use_buf = is_capture & ~debug_halt_mode & (rd_state_reg != TCVB_RD_OPEN); // (R11)
   assign rd_word = use_buf ? rd_buf_reg : val_reg;

   always_ff @(posedge pclk or negedge presetn)
   begin
      if (!presetn)
      begin
         prdata_reg <= 32'h00000000;
      end
      else if (psel && !penable && !pwrite)
      begin
         if (hit(paddr, tcvb_pkg::OFF_CHSC))
         begin
            prdata_reg <= {24'h000000, chsc_reg, 2'h0};
         end
         else if (hit(paddr, tcvb_pkg::OFF_VALH))
         begin
            prdata_reg <= {24'h000000, rd_word[15:8]};
         end
         else if (hit(paddr, tcvb_pkg::OFF_VALL))
         begin
            prdata_reg <= {24'h000000, rd_word[7:0]};
         end
         else if (hit(paddr, tcvb_pkg::OFF_SETUP))
         begin
            prdata_reg <= {26'h0, center_pwm_select, counter_clock_select, 3'h0};
         end
         else
         begin
            prdata_reg <= 32'h00000000;
         end
      end
   end

   assign prdata = prdata_reg;

   // ----------------------------------------
   // Pin driver
   // ----------------------------------------
   always_ff @(posedge pclk or negedge presetn)
   begin
      if (!presetn)
      begin
         ch_pin_out <= 1'b0;
      end
      else if (chsc_reg.els != tcvb_pkg::ELS_OFF)
      begin
         case (mode)
            tcvb_pkg::TCVB_COMPARE:
            begin
               if (match_evt)
               begin
                  case (chsc_reg.els)
                     tcvb_pkg::ELS_TOGGLE: ch_pin_out <= ~ch_pin_out; // (R03)
                     tcvb_pkg::ELS_CLEAR: ch_pin_out <= 1'b0; // (R03)
                     default: ch_pin_out <= 1'b1; // (R03)
                  endcase
               end
            end
            tcvb_pkg::TCVB_EDGE_ALIGNED_PWM:
            begin
               if (match_evt)
               begin
                  ch_pin_out <= ~high_true; // (R04)
               end
               else if (cnt.tick && cnt.value == tcvb_pkg::CNT_ZERO)
               begin
                  ch_pin_out <= high_true; // (R04)
               end
            end
            tcvb_pkg::TCVB_CENTER_ALIGNED_PWM:
            begin
               if (match_evt)
               begin
                  ch_pin_out <= cnt.up ? ~high_true : high_true; // (R05)
               end
            end
            default: ch_pin_out <= ch_pin_out;
         endcase
      end
   end

   assign ch_pin_oe = (chsc_reg.els != tcvb_pkg::ELS_OFF) & ~is_capture; // (R01)

endmodule

// [inc/tcvb_pkg.sv]
package tcvb_pkg;

   // ----------------------------------------
   // Bus geometry and register offsets
   // ----------------------------------------
   localparam int unsigned ADDR_W = 4;
   localparam logic [3:0] OFF_CHSC = 4'h0;
   localparam logic [3:0] OFF_VALH = 4'h4;
   localparam logic [3:0] OFF_VALL = 4'h8;
   localparam logic [3:0] OFF_SETUP = 4'hC;

   // ----------------------------------------
   // Field positions
   // ----------------------------------------
   localparam int unsigned CHSC_FLAG_BIT = 7;
   localparam int unsigned CHSC_IE_BIT = 6;
   localparam int unsigned CHSC_MS_LSB = 4;
   localparam int unsigned CHSC_ELS_LSB = 2;
   localparam int unsigned SETUP_CENTER_ALIGNED_PWM_BIT = 5;
   localparam int unsigned SETUP_CLKS_LSB = 3;

   // ----------------------------------------
   // Reset values and counter constants
   // ----------------------------------------
   localparam logic [15:0] VAL_RST = 16'h0000;
   localparam logic [1:0] CLKS_RST = 2'h0;
   localparam logic [15:0] FREE_TERM = 16'hFFFF;
   localparam logic [15:0] CNT_ZERO = 16'h0000;

   // ----------------------------------------
   // Encodings
   // ----------------------------------------
   localparam logic [1:0] MS_CAPTURE = 2'h0;
   localparam logic [1:0] MS_COMPARE = 2'h1;
   localparam logic [1:0] ELS_OFF = 2'h0;
   localparam logic [1:0] ELS_RISE = 2'h1;
   localparam logic [1:0] ELS_FALL = 2'h2;
   localparam logic [1:0] ELS_BOTH = 2'h3;
   localparam logic [1:0] ELS_TOGGLE = 2'h1;
   localparam logic [1:0] ELS_CLEAR = 2'h2;
   localparam logic [1:0] ELS_SET = 2'h3;
   localparam logic [1:0] ELS_HIGH_TRUE = 2'h2;

   typedef enum logic [1:0] {TCVB_CAPTURE, TCVB_COMPARE, TCVB_EDGE_ALIGNED_PWM, TCVB_CENTER_ALIGNED_PWM} tcvb_mode_t;

   // Shared counter view
   typedef struct packed {
      logic [15:0] value;
      logic [15:0] modulo;
      logic tick;
      logic up;
   } tcvb_cnt_t;

   // Channel status/control contents
   typedef struct packed {
      logic flag;
      logic irq_en;
      logic [1:0] ms;
      logic [1:0] els;
   } tcvb_chsc_t;

endpackage
